//--- sensor_path_regs.svh
`ifndef SENSOR_PATH_REGS_SVH
`define SENSOR_PATH_REGS_SVH
`define ADC_BITS 10
`define ADDR_BITS 10
`define CLK_PERIOD_NS 8
`define ADC_VALID_NS 20
`define ADC_VALID_CYC ((`ADC_VALID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_LEN_NS 100
`define CAL_LEN_CYC ((`CAL_LEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_POS_NS 100
`define CAL_POS_CYC ((`CAL_POS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_HALF_CYC 4
`define REG_CTRL 32'h0000_0000
`define REG_ADDR 32'h0000_0004
`define REG_CMD 32'h0000_0008
`define REG_STATUS 32'h0000_000C
`define REG_DATA 32'h0000_0010
`define CTRL_GAIN_LSB 0
`define CTRL_POL 2
`define CTRL_FLOAT 3
`define CTRL_TPCLR 4
`define CTRL_CONV 5
`define CMD_ROW 0
`define CMD_COL 1
`define CMD_CAL 2
`define CMD_FRAME 3
`define CTRL_RESET 32'h0000_0004
`endif

//--- sensor_path_pkg.sv
package sensor_path_pkg;
  typedef logic [9:0] word10_t;
  typedef enum logic [1:0] {
    GAIN_X1 = 2'b00,
    GAIN_X2 = 2'b01,
    GAIN_X4 = 2'b10,
    GAIN_X6 = 2'b11
  } gain_e;
  typedef enum logic [3:0] {
    LT_IDLE = 4'b0001,
    LT_SETUP = 4'b0010,
    LT_HOLD = 4'b0100,
    LT_DONE = 4'b1000
  } latch_e;
endpackage : sensor_path_pkg

//--- sensor_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if;
  logic [9:0] addressBus;
  logic rowAddressLatch;
  logic columnAddressLatch;
  logic gainSelectLow;
  logic gainSelectHigh;
  logic ampCalibrate;
  logic adcPolaritySelect;
  logic adcFloat;
  logic adcConvClock;
  logic testPixelClear;
  logic [9:0] adcDataOut;
  logic [9:0] adcDataOe;
  wire [9:0] adcDataPins = adcDataOut & adcDataOe;
  modport device (
    input addressBus, rowAddressLatch, columnAddressLatch, gainSelectLow, gainSelectHigh,
    input ampCalibrate, adcPolaritySelect, adcFloat, adcConvClock, testPixelClear,
    output adcDataOut, adcDataOe
  );
  modport controller (
    output addressBus, rowAddressLatch, columnAddressLatch, gainSelectLow, gainSelectHigh,
    output ampCalibrate, adcPolaritySelect, adcFloat, adcConvClock, testPixelClear,
    input adcDataPins
  );
endinterface : sensor_link_if
`default_nettype wire

//--- sensor_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_path_regs.svh"
module sensor_device
  import sensor_path_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clockEnable,
  sensor_link_if.device link,
  input wire logic [9:0] pixelLevel,
  output logic [9:0] rowAddress,
  output logic [9:0] columnAddress,
  output logic [2:0] ampGain,
  output logic ampInCalibration,
  output logic testPixelInReset
);
  typedef struct packed {
    logic [1:0] convSync;
    logic [1:0] rowSync;
    logic [1:0] colSync;
    logic [1:0] floatSync;
    logic [1:0] polSync;
    logic [1:0] calSync;
    logic [1:0] tpSync;
    logic [1:0] g0Sync;
    logic [1:0] g1Sync;
    logic [19:0] addrSync;
    logic convPrev;
    word10_t data;
    logic [9:0] oe;
    word10_t rowAddr;
    word10_t colAddr;
    logic [2:0] gain;
    logic cal;
    logic tp;
  } dev_s;
  dev_s st_r, st_nxt;
  word10_t busValue;
  always_comb begin
    st_nxt = st_r;
    st_nxt.convSync = {st_r.convSync[0], link.adcConvClock};
    st_nxt.rowSync = {st_r.rowSync[0], link.rowAddressLatch};
    st_nxt.colSync = {st_r.colSync[0], link.columnAddressLatch};
    st_nxt.floatSync = {st_r.floatSync[0], link.adcFloat};
    st_nxt.polSync = {st_r.polSync[0], link.adcPolaritySelect};
    st_nxt.calSync = {st_r.calSync[0], link.ampCalibrate};
    st_nxt.tpSync = {st_r.tpSync[0], link.testPixelClear};
    st_nxt.g0Sync = {st_r.g0Sync[0], link.gainSelectLow};
    st_nxt.g1Sync = {st_r.g1Sync[0], link.gainSelectHigh};
    st_nxt.addrSync = {st_r.addrSync[9:0], link.addressBus};
    st_nxt.convPrev = st_r.convSync[1];
    // bus pin 9 carries the address LSB, so reverse into natural order
    busValue = {<<{st_r.addrSync[19:10]}};
    if (!st_r.rowSync[1]) st_nxt.rowAddr = busValue;
    if (!st_r.colSync[1]) st_nxt.colAddr = busValue;
    case ({st_r.g1Sync[1], st_r.g0Sync[1]})
      GAIN_X1: st_nxt.gain = 3'd1;
      GAIN_X2: st_nxt.gain = 3'd2;
      GAIN_X4: st_nxt.gain = 3'd4;
      GAIN_X6: st_nxt.gain = 3'd6;
      default: st_nxt.gain = 3'd1;
    endcase
    st_nxt.cal = st_r.calSync[1];
    // calibration forces unity gain while held high
    if (st_r.calSync[1]) st_nxt.gain = 3'd1;
    st_nxt.tp = st_r.tpSync[1];
    // sample on the falling edge of the synchronised conversion clock
    if (st_r.convPrev && !st_r.convSync[1]) begin
      // calibrate presents black, which is code zero before polarity
      st_nxt.data = st_r.calSync[1] ? 10'h000 : pixelLevel;
      if (!st_r.polSync[1]) st_nxt.data = ~st_nxt.data;
    end
    st_nxt.oe = st_r.floatSync[1] ? 10'h000 : 10'h3FF;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else if (clockEnable) begin
      st_r <= st_nxt;
    end
  end
  assign link.adcDataOut = st_r.data;
  assign link.adcDataOe = st_r.oe;
  assign rowAddress = st_r.rowAddr;
  assign columnAddress = st_r.colAddr;
  assign ampGain = st_r.gain;
  assign ampInCalibration = st_r.cal;
  assign testPixelInReset = st_r.tp;
endmodule : sensor_device
`default_nettype wire

//--- sensor_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_path_regs.svh"
module sensor_controller
  import sensor_path_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clockEnable,
  sensor_link_if.controller link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    logic [31:0] ctrl;
    word10_t addr;
    latch_e lt;
    logic ltRow;
    logic [7:0] cnt;
    logic rowDone;
    logic colDone;
    logic calUsed;
    logic calPend;
    logic calOn;
    logic [7:0] calCnt;
    logic [2:0] convCnt;
    logic conv;
    logic [3:0] validCnt;
    word10_t sample;
    logic sampleNew;
    logic [19:0] dataSync;
    word10_t busOut;
    logic rowL;
    logic colL;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } ctl_s;
  ctl_s st_r, st_nxt;
  logic acc;
  always_comb begin
    st_nxt = st_r;
    acc = psel && penable && !st_r.ready;
    st_nxt.ready = acc;
    st_nxt.err = 1'b0;
    st_nxt.dataSync = {st_r.dataSync[9:0], link.adcDataPins};
    if (acc) begin
      case (paddr)
        `REG_CTRL: begin
          if (pwrite) st_nxt.ctrl = {26'h0, pwdata[5:0]};
          st_nxt.rdata = st_r.ctrl;
        end
        `REG_ADDR: begin
          if (pwrite) st_nxt.addr = pwdata[9:0];
          st_nxt.rdata = {22'h0, st_r.addr};
        end
        `REG_CMD: begin
          if (pwrite) begin
            if (pwdata[`CMD_ROW] && st_r.lt == LT_IDLE) begin
              st_nxt.lt = LT_SETUP;
              st_nxt.ltRow = 1'b1;
            end else if (pwdata[`CMD_COL] && st_r.lt == LT_IDLE) begin
              st_nxt.lt = LT_SETUP;
              st_nxt.ltRow = 1'b0;
            end
            // one calibration pulse per frame
            if (pwdata[`CMD_CAL] && !st_r.calUsed) st_nxt.calPend = 1'b1;
            if (pwdata[`CMD_FRAME]) st_nxt.calUsed = 1'b0;
          end
          st_nxt.rdata = 32'h0;
        end
        `REG_STATUS: begin
          st_nxt.rdata = {26'h0, st_r.sampleNew, st_r.calUsed, st_r.calOn,
                          st_r.lt == LT_IDLE, st_r.colDone, st_r.rowDone};
        end
        `REG_DATA: begin
          st_nxt.rdata = {22'h0, st_r.sample};
          if (!pwrite) st_nxt.sampleNew = 1'b0;
        end
        default: begin
          st_nxt.rdata = 32'h0;
          st_nxt.err = 1'b1;
        end
      endcase
    end
    // latch sequence: present address with latch low, then raise to hold
    case (st_r.lt)
      LT_IDLE: st_nxt.cnt = 8'd0;
      LT_SETUP: begin
        st_nxt.busOut = {<<{st_r.addr}};
        if (st_r.ltRow) st_nxt.rowL = 1'b0;
        else st_nxt.colL = 1'b0;
        st_nxt.cnt = st_r.cnt + 8'd1;
        if (st_r.cnt == 8'd4) begin
          st_nxt.lt = LT_HOLD;
          st_nxt.cnt = 8'd0;
        end
      end
      LT_HOLD: begin
        st_nxt.rowL = 1'b1;
        st_nxt.colL = 1'b1;
        st_nxt.lt = LT_DONE;
      end
      LT_DONE: begin
        // completion sets the row or column done flag reported in the status register
        if (st_r.ltRow) st_nxt.rowDone = 1'b1;
        else st_nxt.colDone = 1'b1;
        st_nxt.lt = LT_IDLE;
      end
      default: st_nxt.lt = LT_IDLE;
    endcase
    if (st_r.calPend && !st_r.calOn) begin
      st_nxt.calPend = 1'b0;
      st_nxt.calOn = 1'b1;
      st_nxt.calUsed = 1'b1;
      st_nxt.calCnt = 8'd0;
    end else if (st_r.calOn) begin
      st_nxt.calCnt = st_r.calCnt + 8'd1;
      if (st_r.calCnt == 8'(`CAL_LEN_CYC - 1)) st_nxt.calOn = 1'b0;
    end
    // free-running conversion clock while enabled
    if (st_r.ctrl[`CTRL_CONV]) begin
      st_nxt.convCnt = st_r.convCnt + 3'd1;
      if (st_r.convCnt == 3'(`CONV_HALF_CYC - 1)) begin
        st_nxt.convCnt = 3'd0;
        st_nxt.conv = !st_r.conv;
        if (st_r.conv) st_nxt.validCnt = 4'd1;
      end
    end
    if (st_r.validCnt != 4'd0) begin
      st_nxt.validCnt = st_r.validCnt + 4'd1;
      // wait the valid delay plus the device and local synchroniser stages
      if (st_r.validCnt == 4'(`ADC_VALID_CYC + 6)) begin
        st_nxt.validCnt = 4'd0;
        st_nxt.sample = st_r.dataSync[19:10];
        st_nxt.sampleNew = 1'b1;
      end
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.ctrl <= `CTRL_RESET;
      st_r.lt <= LT_IDLE;
      st_r.rowL <= 1'b1;
      st_r.colL <= 1'b1;
    end else if (clockEnable) begin
      st_r <= st_nxt;
    end
  end
  assign link.addressBus = st_r.busOut;
  assign link.rowAddressLatch = st_r.rowL;
  assign link.columnAddressLatch = st_r.colL;
  assign link.gainSelectLow = st_r.ctrl[`CTRL_GAIN_LSB];
  assign link.gainSelectHigh = st_r.ctrl[`CTRL_GAIN_LSB + 1];
  assign link.ampCalibrate = st_r.calOn;
  assign link.adcPolaritySelect = st_r.ctrl[`CTRL_POL];
  assign link.adcFloat = st_r.ctrl[`CTRL_FLOAT];
  assign link.adcConvClock = st_r.conv;
  assign link.testPixelClear = st_r.ctrl[`CTRL_TPCLR];
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
endmodule : sensor_controller
`default_nettype wire

//--- sensor_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_path_regs.svh"
module sensor_link_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [9:0] addressBus,
  input wire logic rowAddressLatch,
  input wire logic columnAddressLatch,
  input wire logic ampCalibrate,
  input wire logic adcFloat,
  input wire logic adcConvClock,
  input wire logic [9:0] adcDataOe
);
  logic [7:0] calCount_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      calCount_r <= 8'h00;
    end else begin
      calCount_r <= ampCalibrate ? calCount_r + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence lowThenHold(l);
    !l[*5] ##1 l;
  endsequence
  sequence convCycle;
    adcConvClock[*4] ##1 !adcConvClock[*4] ##1 adcConvClock;
  endsequence
  a_row_latch_pulse: assert property ($fell(rowAddressLatch) |-> lowThenHold(rowAddressLatch))
    else $error("row latch pulse length wrong");
  a_col_latch_pulse: assert property ($fell(columnAddressLatch) |-> lowThenHold(columnAddressLatch))
    else $error("column latch pulse length wrong");
  // the bus must not move while a register is tracking it
  a_addr_hold_stable: assert property ((!rowAddressLatch || !columnAddressLatch) && !$fell(rowAddressLatch) && !$fell(columnAddressLatch) |-> $stable(addressBus))
    else $error("address bus moved during latch");
  a_latch_one_only: assert property (rowAddressLatch || columnAddressLatch)
    else $error("both latches tracking");
  a_cal_pulse_width: assert property ($fell(ampCalibrate) |-> calCount_r == `CAL_LEN_CYC)
    else $error("calibrate pulse length wrong");
  a_conv_clock_period: assert property ($rose(adcConvClock) |-> convCycle)
    else $error("conversion clock period wrong");
  a_float_release: assert property (adcFloat[*5] |-> adcDataOe == 10'h000)
    else $error("data outputs driven while floated");
  a_drive_normal: assert property (!adcFloat[*5] |-> adcDataOe == 10'h3FF)
    else $error("data outputs not driven");
endmodule : sensor_link_monitor
`default_nettype wire

//--- test_image_sensor_output_path_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_path_regs.svh"
module test_image_sensor_output_path_control;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd;
  logic [9:0] pixelLevel = 10'h000, rowAddress, columnAddress;
  logic [2:0] ampGain;
  logic ampInCalibration, testPixelInReset;
  logic [2:0] gainX [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  int n_mismatch = 0, cmp_count = 0;
  sensor_link_if link();
  sensor_device sensor_device_inst (.clock(clock), .rstn(rstn), .clockEnable(1'b1), .link(link),
    .pixelLevel(pixelLevel), .rowAddress(rowAddress), .columnAddress(columnAddress),
    .ampGain(ampGain), .ampInCalibration(ampInCalibration), .testPixelInReset(testPixelInReset));
  sensor_controller sensor_controller_inst (.clock(clock), .rstn(rstn), .clockEnable(1'b1),
    .link(link), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sensor_link_monitor sensor_link_monitor_inst (.clock(clock), .rstn(rstn),
    .addressBus(link.addressBus), .rowAddressLatch(link.rowAddressLatch),
    .columnAddressLatch(link.columnAddressLatch), .ampCalibrate(link.ampCalibrate),
    .adcFloat(link.adcFloat), .adcConvClock(link.adcConvClock), .adcDataOe(link.adcDataOe));
  initial begin
    forever #4 clock = ~clock;
  end
  task test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // a wait that runs out of cycles is a mismatch and ends the run
  task bound(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      test_done();
    end
  endtask : bound
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // reads at a rising edge see the values that edge samples
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 50) begin
      n_mismatch++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task pollBit(input int b);
    int k;
    for (k = 0; k < 100; k++) begin
      apb(1'b0, `REG_STATUS, 32'h0000_0000);
      if (rd[b] === 1'b1) break;
    end
    if (k == 100) begin
      n_mismatch++;
      test_done();
    end
  endtask : pollBit
  // first samples after a control change may predate it, so keep the third
  task sample(input logic [31:0] exp);
    repeat (3) begin
      pollBit(5);
      apb(1'b0, `REG_DATA, 32'h0000_0000);
    end
    chk(rd, exp);
  endtask : sample
  task latch(input logic [31:0] cmd, input logic [9:0] a);
    int k;
    logic [9:0] r;
    r = {<<{a}};
    apb(1'b1, `REG_ADDR, {22'h00_0000, a});
    apb(1'b1, `REG_CMD, cmd);
    for (k = 0; k < 20 && link.rowAddressLatch && link.columnAddressLatch; k++) @(posedge clock);
    bound(k, 20);
    chk(link.addressBus, r);
    pollBit(cmd == 1 ? 0 : 1);
  endtask : latch
  initial begin
    int g, c;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    apb(1'b0, `REG_CTRL, 32'h0000_0000);
    chk(rd, `CTRL_RESET);
    apb(1'b0, 32'h0000_0020, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    for (g = 0; g < 4; g++) begin
      apb(1'b1, `REG_CTRL, 32'h0000_0024 | g);
      repeat (6) @(posedge clock);
      chk(ampGain, gainX[g]);
      chk({link.gainSelectHigh, link.gainSelectLow}, g[1:0]);
    end
    latch(32'h0000_0001, 10'h001);
    chk(rowAddress, 10'h001);
    latch(32'h0000_0002, 10'h2A5);
    chk(columnAddress, 10'h2A5);
    chk(rowAddress, 10'h001);
    apb(1'b1, `REG_CTRL, 32'h0000_0037);
    repeat (6) @(posedge clock);
    chk(testPixelInReset, 1'b1);
    apb(1'b1, `REG_CTRL, 32'h0000_002F);
    repeat (6) @(posedge clock);
    chk(testPixelInReset, 1'b0);
    chk(link.adcDataOe, 10'h000);
    chk(link.adcDataPins, 10'h000);
    apb(1'b1, `REG_CTRL, 32'h0000_0027);
    repeat (6) @(posedge clock);
    chk(link.adcDataOe, 10'h3FF);
    pixelLevel <= 10'h123;
    sample(32'h0000_0123);
    apb(1'b1, `REG_CTRL, 32'h0000_0023);
    sample(32'h0000_02DC);
    pixelLevel <= 10'h000;
    sample(32'h0000_03FF);
    apb(1'b1, `REG_CMD, 32'h0000_0008);
    apb(1'b1, `REG_CMD, 32'h0000_0004);
    for (c = 0; c < 40 && ampInCalibration !== 1'b1; c++) @(posedge clock);
    bound(c, 40);
    chk(ampInCalibration, 1'b1);
    repeat (2) @(posedge clock);
    chk(ampGain, 3'h1);
    for (c = 0; c < 40 && link.ampCalibrate !== 1'b0; c++) @(posedge clock);
    bound(c, 40);
    apb(1'b1, `REG_CMD, 32'h0000_0004);
    c = 0;
    repeat (40) begin
      @(posedge clock);
      c += int'(link.ampCalibrate === 1'b1);
    end
    chk(c, 32'h0000_0000);
    test_done();
  end
endmodule : test_image_sensor_output_path_control
`default_nettype wire
